//--- rtl/dsv_pkg.sv
// Purpose: constants for the soft-step volume stage
// Assumes: 32-bit classic wishbone, word index = byte address / 4
// Notes:   gain codes count 0.5 dB attenuation steps, 8'h80 is mute
package dsv_pkg;
    // ====================================
    // register indices (byte address = 4 * index)
    localparam logic [7:0] IDX_VOL_L = 8'h00;
    localparam logic [7:0] IDX_VOL_R = 8'h01;
    localparam logic [7:0] IDX_VOL_M = 8'h02;
    localparam logic [7:0] IDX_CTRL  = 8'h03;
    localparam logic [7:0] IDX_PWR   = 8'h04;
    localparam logic [7:0] IDX_STAT  = 8'h05;
    localparam logic [7:0] IDX_INLVL = 8'h06;
    localparam logic [7:0] IDX_INCFG = 8'h07;
    localparam logic [7:0] IDX_CM    = 8'h08;
    localparam logic [7:0] IDX_DIV   = 8'h09;
    localparam logic [7:0] IDX_BIAS  = 8'h6d;
    // ====================================
    // field positions
    localparam int VOL_MUTE   = 7;
    localparam int CTRL_SOFT  = 0;  // 1 = soft-step off
    localparam int CTRL_HALF  = 1;  // 1 = one step per two samples
    localparam int CTRL_DEEMP = 2;
    localparam int CTRL_EFFX  = 3;
    localparam int PWR_DAC    = 0;
    localparam int PWR_L      = 1;
    localparam int PWR_R      = 2;
    localparam int ST_DONE_L  = 0;
    localparam int ST_DONE_R  = 1;
    localparam int ST_PDN     = 2;
    localparam int ST_FBUSY   = 3;
    localparam int BIAS_LSB   = 6;
    // ====================================
    // codes and reset values
    localparam logic [7:0] MUTE_CODE = 8'h80;
    localparam logic [3:0] IN_MAX    = 4'h8;   // 8 x 1.5 dB = -12 dB
    localparam logic [7:0] RST_VOL   = 8'h80;
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [7:0] RST_PWR   = 8'h00;
    localparam logic [7:0] RST_INLVL = 8'h00;
    localparam logic [7:0] RST_INCFG = 8'h00;
    localparam logic [1:0] RST_CM    = 2'h0;
    localparam logic [7:0] RST_DIV   = 8'hcf;  // mclk cycles per sample - 1
    localparam logic [7:0] RST_BIAS  = 8'h00;  // lowest bias current
    // sequencer states
    typedef enum logic [1:0] {DSV_OFF, DSV_RUN, DSV_FMUTE, DSV_DOWN} dsv_state_e;
endpackage

//--- rtl/dsv_tick.sv
// Purpose: sample-rate strobe from mclk
// Assumes: period = div + 1 mclk cycles
// Notes:   a new divider value is compared at once; a count already past it runs on through 255
module dsv_tick (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [7:0] div,
    output logic            tick_q
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       tick_d;

    // ====================================
    // divider
    always_comb begin
        tick_d = (cnt_q == div);
        cnt_d  = tick_d ? 8'h00 : cnt_q + 8'h01;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end
endmodule

//--- rtl/dsv_ramp.sv
// Purpose: one soft-stepped gain value
// Assumes: tick is a one-cycle sample strobe
// Notes:   force or soft_off loads the target directly
module dsv_ramp #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic         tick,
    input  wire logic         half,
    input  wire logic         soft_off,
    input  wire logic         force_ld,
    input  wire logic [W-1:0] target,
    output logic      [W-1:0] applied_q
);
    logic [W-1:0] applied_d;
    logic         phase_q;
    logic         phase_d;
    logic         step;

    // ====================================
    // one step per tick, or per two ticks in half mode
    always_comb begin
        phase_d   = tick ? ~phase_q : phase_q;
        step      = tick && (!half || phase_q);
        applied_d = applied_q;
        if (soft_off || force_ld) begin
            applied_d = target;
        end else if (step && applied_q < target) begin
            applied_d = applied_q + W'(1);
        end else if (step && applied_q > target) begin
            applied_d = applied_q - W'(1);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            applied_q <= RST;
            phase_q   <= 1'b0;
        end else begin
            applied_q <= applied_d;
            phase_q   <= phase_d;
        end
    end
endmodule

//--- rtl/dsv_top.sv
// Purpose: dac digital volume with soft-step, power and filter sequencing
// Assumes: classic wishbone slave, one clock mclk, 8-bit registers
// Notes:   applied gain leaves through gain_l/gain_r, 8'h80 = mute
//
// Summary of operation
// [R1] per-channel 0.5 dB gain plus mute
// [R2] master write sets both targets
// [R3] one step per sample toward target
// [R4] half-rate bit: step every second sample
// [R5] read-only done flag when applied equals target
// [R6] soft-step off applies gain at once
// [R7] host keeps clock until power-down flag
// [R8] filter switch: mute, change, unmute
// [R9] power-up starts muted then ramps up
// [R10] power-down ramps to mute, then off
// [R11] two-bit bias field in register 109
// [R12] four-step output common-mode select
// [R13] whole dac and per-channel analog power
// [R14] input level 0 to -12 dB, 1.5 dB
// [R15] input level ramps per input amp settings
// [R16] host keeps shared inputs configured alike
// [R17] done clears on differing target write
//
// Decided for this implementation: the Wishbone slave port.
module dsv_top
    import dsv_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [7:0]  gain_l,
    output logic      [7:0]  gain_r,
    output logic             deemph_on,
    output logic             effects_on,
    output logic             dac_on,
    output logic             chan_l_on,
    output logic             chan_r_on,
    output logic      [1:0]  cm_sel,
    output logic      [1:0]  bias_sel,
    output logic      [3:0]  in_lvl_l,
    output logic      [3:0]  in_lvl_r,
    output logic             sample_tick
);
    import dsv_pkg::*;

    // ====================================
    // bus slave state
    logic        ack_q;        // answer, one cycle
    logic        ack_d;
    logic [31:0] rdat_q;       // read data, loaded with ack
    logic [31:0] rdat_d;
    logic [7:0]  idx;          // word index
    logic        wr_en;        // write commits at ack edge
    logic [7:0]  wbyte;        // low lane

    // ====================================
    // register file
    logic [7:0] vol_l_q, vol_l_d;
    logic [7:0] vol_r_q, vol_r_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] pwr_q, pwr_d;
    logic [7:0] inlvl_q, inlvl_d;
    logic [7:0] incfg_q, incfg_d;
    logic [1:0] cm_q, cm_d;
    logic [7:0] div_q, div_d;
    logic [7:0] bias_q, bias_d;

    // ====================================
    // sequencer state
    dsv_state_e st_q, st_d;
    logic       deemp_q, deemp_d;  // applied filter switches
    logic       effx_q, effx_d;
    logic       dac_on_q, dac_on_d;
    logic       chl_q, chl_d;
    logic       chr_q, chr_d;

    // ====================================
    // datapath glue
    logic [7:0] prog_l;     // programmed target, mute folded in
    logic [7:0] prog_r;
    logic [7:0] tgt_l;      // target handed to ramps
    logic [7:0] tgt_r;
    logic       muted;      // both channels at mute
    logic       filt_req;   // software asks a filter change
    logic [3:0] in_tl;      // clamped input level targets
    logic [3:0] in_tr;
    logic       tick;

    assign idx   = wb_adr_i[9:2];
    assign wbyte = wb_dat_i[7:0];
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

    // ====================================
    // target composition
    always_comb begin
        // mute sits one code beyond -63.5 dB so soft mute walks every step
        prog_l = vol_l_q[VOL_MUTE] ? MUTE_CODE : {1'b0, vol_l_q[6:0]}; // R1
        prog_r = vol_r_q[VOL_MUTE] ? MUTE_CODE : {1'b0, vol_r_q[6:0]}; // R1
        // only the run state lets the programmed level through
        tgt_l  = (st_q == DSV_RUN) ? prog_l : MUTE_CODE; // R8 R9 R10
        tgt_r  = (st_q == DSV_RUN) ? prog_r : MUTE_CODE;
        muted  = (gain_l == MUTE_CODE) && (gain_r == MUTE_CODE);
        filt_req = (ctrl_q[CTRL_DEEMP] != deemp_q) || (ctrl_q[CTRL_EFFX] != effx_q);
        in_tl  = inlvl_q[3:0];
        in_tr  = inlvl_q[7:4];
    end

    // ====================================
    // sample strobe and ramps
    dsv_tick u_tick (
        .mclk   (mclk),
        .arst_n (arst_n),
        .div    (div_q),
        .tick_q (tick)
    );

    // dac ramps; forced to mute while the converter is off
    dsv_ramp #(.W(8), .RST(MUTE_CODE)) u_ramp_l (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .tick      (tick),
        .half      (ctrl_q[CTRL_HALF]),  // R4
        .soft_off  (ctrl_q[CTRL_SOFT]),  // R6
        .force_ld  (st_q == DSV_OFF),    // R9
        .target    (tgt_l),              // R3
        .applied_q (gain_l)
    );

    dsv_ramp #(.W(8), .RST(MUTE_CODE)) u_ramp_r (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .tick      (tick),
        .half      (ctrl_q[CTRL_HALF]),  // R4
        .soft_off  (ctrl_q[CTRL_SOFT]),  // R6
        .force_ld  (st_q == DSV_OFF),
        .target    (tgt_r),              // R3
        .applied_q (gain_r)
    );

    // input level ramps follow the input amplifier soft-step setting
    dsv_ramp #(.W(4), .RST(4'h0)) u_in_l (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .tick      (tick),
        .half      (incfg_q[CTRL_HALF]), // R15
        .soft_off  (incfg_q[CTRL_SOFT]), // R15
        .force_ld  (1'b0),
        .target    (in_tl),              // R14
        .applied_q (in_lvl_l)
    );

    dsv_ramp #(.W(4), .RST(4'h0)) u_in_r (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .tick      (tick),
        .half      (incfg_q[CTRL_HALF]), // R15
        .soft_off  (incfg_q[CTRL_SOFT]), // R15
        .force_ld  (1'b0),
        .target    (in_tr),              // R14
        .applied_q (in_lvl_r)
    );

    // ====================================
    // register writes
    always_comb begin
        vol_l_d = vol_l_q;
        vol_r_d = vol_r_q;
        ctrl_d  = ctrl_q;
        pwr_d   = pwr_q;
        inlvl_d = inlvl_q;
        incfg_d = incfg_q;
        cm_d    = cm_q;
        div_d   = div_q;
        bias_d  = bias_q;
        if (wr_en) begin
            if (idx == IDX_VOL_L) begin
                vol_l_d = wbyte; // R1 R17
            end else if (idx == IDX_VOL_R) begin
                vol_r_d = wbyte; // R1 R17
            end else if (idx == IDX_VOL_M) begin
                // one write moves both targets together
                vol_l_d = wbyte; // R2
                vol_r_d = wbyte; // R2
            end else if (idx == IDX_CTRL) begin
                ctrl_d = {4'h0, wbyte[3:0]};
            end else if (idx == IDX_PWR) begin
                pwr_d = {5'h00, wbyte[2:0]}; // R13
            end else if (idx == IDX_INLVL) begin
                // codes past -12 dB clamp rather than wrap
                inlvl_d[3:0] = (wbyte[3:0] > IN_MAX) ? IN_MAX : wbyte[3:0]; // R14
                inlvl_d[7:4] = (wbyte[7:4] > IN_MAX) ? IN_MAX : wbyte[7:4]; // R14
            end else if (idx == IDX_INCFG) begin
                incfg_d = {6'h00, wbyte[1:0]}; // R15
            end else if (idx == IDX_CM) begin
                cm_d = wbyte[1:0]; // R12
            end else if (idx == IDX_DIV) begin
                div_d = wbyte;
            end else if (idx == IDX_BIAS) begin
                bias_d = wbyte; // R11
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vol_l_q <= RST_VOL;
            vol_r_q <= RST_VOL;
            ctrl_q  <= RST_CTRL;
            pwr_q   <= RST_PWR;
            inlvl_q <= RST_INLVL;
            incfg_q <= RST_INCFG;
            cm_q    <= RST_CM;
            div_q   <= RST_DIV;
            bias_q  <= RST_BIAS;
        end else begin
            vol_l_q <= vol_l_d;
            vol_r_q <= vol_r_d;
            ctrl_q  <= ctrl_d;
            pwr_q   <= pwr_d;
            inlvl_q <= inlvl_d;
            incfg_q <= incfg_d;
            cm_q    <= cm_d;
            div_q   <= div_d;
            bias_q  <= bias_d;
        end
    end

    // ====================================
    // power and filter sequencer
    always_comb begin
        st_d     = st_q;
        deemp_d  = deemp_q;
        effx_d   = effx_q;
        dac_on_d = dac_on_q;
        case (st_q)
            DSV_OFF: begin
                // nothing audible: filters may switch at once
                deemp_d = ctrl_q[CTRL_DEEMP];
                effx_d  = ctrl_q[CTRL_EFFX];
                if (pwr_q[PWR_DAC]) begin
                    dac_on_d = 1'b1; // R9 R13
                    st_d     = DSV_RUN;
                end
            end
            DSV_RUN: begin
                if (!pwr_q[PWR_DAC]) begin
                    st_d = DSV_DOWN; // R10
                end else if (filt_req) begin
                    st_d = DSV_FMUTE; // R8
                end
            end
            DSV_FMUTE: begin
                if (!pwr_q[PWR_DAC]) begin
                    st_d = DSV_DOWN;
                end else if (muted) begin
                    // change the filters only once silent
                    deemp_d = ctrl_q[CTRL_DEEMP]; // R8
                    effx_d  = ctrl_q[CTRL_EFFX];  // R8
                    st_d    = DSV_RUN;
                end
            end
            DSV_DOWN: begin
                // dac_on stays set until the ramp lands on mute; channel power follows its own pwr bits
                if (muted) begin
                    dac_on_d = 1'b0; // R10
                    st_d     = DSV_OFF;
                end
            end
            default: begin
                st_d = DSV_OFF;
            end
        endcase
        chl_d = dac_on_d && pwr_q[PWR_L]; // R13
        chr_d = dac_on_d && pwr_q[PWR_R]; // R13
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q     <= DSV_OFF;
            deemp_q  <= 1'b0;
            effx_q   <= 1'b0;
            dac_on_q <= 1'b0;
            chl_q    <= 1'b0;
            chr_q    <= 1'b0;
        end else begin
            st_q     <= st_d;
            deemp_q  <= deemp_d;
            effx_q   <= effx_d;
            dac_on_q <= dac_on_d;
            chl_q    <= chl_d;
            chr_q    <= chr_d;
        end
    end

    // ====================================
    // bus answer and read mux
    always_comb begin
        // ack drops the cycle after it was given
        ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
        rdat_d = rdat_q;
        if (ack_d) begin
            rdat_d = 32'h0000_0000;
            if (idx == IDX_VOL_L || idx == IDX_VOL_M) begin
                rdat_d[7:0] = vol_l_q;
            end else if (idx == IDX_VOL_R) begin
                rdat_d[7:0] = vol_r_q;
            end else if (idx == IDX_CTRL) begin
                rdat_d[7:0] = ctrl_q;
            end else if (idx == IDX_PWR) begin
                rdat_d[7:0] = pwr_q;
            end else if (idx == IDX_STAT) begin
                rdat_d[ST_DONE_L] = (gain_l == prog_l); // R5 R17
                rdat_d[ST_DONE_R] = (gain_r == prog_r); // R5 R17
                rdat_d[ST_PDN]    = (st_q == DSV_OFF);  // R7 R10
                rdat_d[ST_FBUSY]  = (st_q == DSV_FMUTE);
            end else if (idx == IDX_INLVL) begin
                rdat_d[7:0] = inlvl_q;
            end else if (idx == IDX_INCFG) begin
                rdat_d[7:0] = incfg_q;
            end else if (idx == IDX_CM) begin
                rdat_d[1:0] = cm_q;
            end else if (idx == IDX_DIV) begin
                rdat_d[7:0] = div_q;
            end else if (idx == IDX_BIAS) begin
                rdat_d[7:0] = bias_q; // R11
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // ====================================
    // outputs
    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rdat_q;
    assign deemph_on   = deemp_q;
    assign effects_on  = effx_q;
    assign dac_on      = dac_on_q;
    assign chan_l_on   = chl_q;
    assign chan_r_on   = chr_q;
    assign cm_sel      = cm_q;
    assign bias_sel    = bias_q[BIAS_LSB+1:BIAS_LSB];
    assign sample_tick = tick;

    // ====================================
    // half-rate checker helper
    logic [7:0] hr_prev_q, hr_prev_d;  // gain one cycle earlier
    logic       hr_ok_q, hr_ok_d;      // half-rate stepping was in force that cycle
    logic       hr_arm_q, hr_arm_d;    // no sample seen since the last step
    logic       hr_step;               // a half-rate step shows this cycle

    // the phase flips on every sample, so the sample after a step must hold
    always_comb begin
        hr_step   = hr_ok_q && (gain_l != hr_prev_q);
        hr_prev_d = gain_l;
        hr_ok_d   = ctrl_q[CTRL_HALF] && !ctrl_q[CTRL_SOFT] && (st_q != DSV_OFF);
        hr_arm_d  = hr_ok_d && (hr_step || hr_arm_q) && !tick;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hr_prev_q <= MUTE_CODE;
            hr_ok_q   <= 1'b0;
            hr_arm_q  <= 1'b0;
        end else begin
            hr_prev_q <= hr_prev_d;
            hr_ok_q   <= hr_ok_d;
            hr_arm_q  <= hr_arm_d;
        end
    end

    // ====================================
    // checks
    default clocking dsv_cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_off_held_mute: assert property ( // R9
        st_q == DSV_OFF |-> gain_l == MUTE_CODE && gain_r == MUTE_CODE)
        else $error("gain not muted while off");
    a_ramp_one_step: assert property ( // R3
        !ctrl_q[CTRL_SOFT] && !$past(ctrl_q[CTRL_SOFT]) && $past(st_q) != DSV_OFF
        |-> (gain_l - $past(gain_l) == 8'h01) || ($past(gain_l) - gain_l == 8'h01)
            || $stable(gain_l))
        else $error("gain moved more than one step");
    a_step_on_tick: assert property ( // R3
        !$past(tick) && !$past(ctrl_q[CTRL_SOFT]) && $past(st_q) != DSV_OFF
        |-> $stable(gain_l))
        else $error("gain moved without a sample");
    a_half_rate: assert property ( // R4
        ctrl_q[CTRL_HALF] && !ctrl_q[CTRL_SOFT] && st_q != DSV_OFF && tick
        && (hr_step || hr_arm_q) |=> $stable(gain_l))
        else $error("half rate stepped on consecutive samples");
    a_hard_set: assert property ( // R6
        ctrl_q[CTRL_SOFT] && st_q == DSV_RUN |=> gain_l == $past(prog_l))
        else $error("gain not applied at once");
    a_filter_muted: assert property ( // R8
        dac_on_q && $past(dac_on_q) && (deemp_q != $past(deemp_q) || effx_q != $past(effx_q))
        |-> $past(gain_l) == MUTE_CODE && $past(gain_r) == MUTE_CODE)
        else $error("filter changed while audible");
    a_down_muted: assert property ( // R10
        $fell(dac_on_q) |-> gain_l == MUTE_CODE && gain_r == MUTE_CODE)
        else $error("dac off before mute");
    a_done_read: assert property ( // R5
        wb_ack_o && !wb_we_i && $past(idx) == IDX_STAT
        |-> wb_dat_o[ST_DONE_L] == $past(gain_l == prog_l))
        else $error("done flag wrong");
    a_master_both: assert property ( // R2
        wr_en && idx == IDX_VOL_M |=> vol_l_q == $past(wbyte) && vol_r_q == $past(wbyte))
        else $error("master write missed a channel");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held");

    c_power_up: cover property ($rose(dac_on_q) ##[1:1000] gain_l == prog_l);
    c_filter_swap: cover property (st_q == DSV_FMUTE ##[1:1000] st_q == DSV_RUN);
    c_power_down: cover property (st_q == DSV_DOWN ##[1:1000] st_q == DSV_OFF);
endmodule

//--- tb/dsv_host.sv
// Purpose: host model, classic wishbone master for register access
// Assumes: slave answers with a one-cycle ack pulse
// Notes:   request held until ack is seen at a rising edge
module dsv_host (
    input  wire logic        mclk,
    input  wire logic        wb_ack_o,
    input  wire logic [31:0] wb_dat_o,
    output logic             wb_cyc_i,
    output logic             wb_stb_i,
    output logic             wb_we_i,
    output logic      [9:0]  wb_adr_i,
    output logic      [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================
    // idle bus from time zero
    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
    end
    // one transfer; the next call waits an edge, so cyc idles a cycle
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench for the soft-step volume stage
// Assumes: divider set to 3, one sample per 4 mclk
// Notes:   reads are checked from a queue of expected values
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import dsv_pkg::*;
    logic mclk, arst_n, cyc, stb, we, ack, dac_on, de_on, fx_on, l_on, r_on, tick;
    logic [9:0] adr;
    logic [3:0] sel, lvl_l, lvl_r;
    logic [31:0] dat_i, dat_o;
    logic [7:0] gain_l, gain_r, q, pg, tl;
    logic [1:0] cm, bias;
    logic soft_on;
    logic [7:0] exp_q[$];
    int fails, cmp_count, nt, seed;
    dsv_host u_host (.mclk(mclk), .wb_ack_o(ack), .wb_dat_o(dat_o), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i));
    dsv_top u_dsv_top (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .gain_l(gain_l), .gain_r(gain_r), .deemph_on(de_on),
        .effects_on(fx_on), .dac_on(dac_on), .chan_l_on(l_on), .chan_r_on(r_on),
        .cm_sel(cm), .bias_sel(bias), .in_lvl_l(lvl_l), .in_lvl_r(lvl_r),
        .sample_tick(tick));
    // ==========================
    // 100 ns clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] ex);
        cmp_count++;
        if (got !== ex) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask
    task automatic close_out;
        $display("compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        u_host.xfer(1'b1, idx, d, q);
    endtask
    // expected read value queued before the request goes out
    task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
        exp_q.push_back(ex);
        u_host.xfer(1'b0, idx, 8'h00, q);
    endtask
    // bounded wait on a flag: 0 power, 1 de-emphasis, 2 effects
    task automatic wt(input int w, input logic v);
        repeat (4000) begin
            @(posedge mclk);
            if ((w == 0 ? dac_on : w == 1 ? de_on : fx_on) === v) break;
        end
    endtask
    // wait for both gains, counting sample strobes on the way
    task automatic ramp(input logic [7:0] a, input logic [7:0] b);
        nt = 0;
        // a strobe at entry counts: its step may already be under way
        repeat (4000) begin
            if (gain_l === a && gain_r === b) break;
            if (tick === 1'b1) nt++;
            @(posedge mclk);
        end
        chk(gain_l, a);
        chk(gain_r, b);
    endtask
    // ==========================
    // read monitor: compare the oldest note at each read ack
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk(dat_o[7:0], exp_q.pop_front());
    end
    // step monitor: with soft-step on, gain moves one code at a time
    always @(posedge mclk) begin
        if (arst_n === 1'b1 && soft_on && gain_l !== pg)
            chk({7'h0, gain_l === pg + 8'h1 || gain_l === pg - 8'h1}, 8'h01);
        pg <= gain_l;
    end
    // watchdog, far beyond the few thousand cycles of the tests
    initial begin
        #3000000;
        fails++;
        close_out();
    end
    initial begin
        arst_n = 1'b0;
        soft_on = 1'b1;
        seed = 80118;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        rd(IDX_VOL_L, RST_VOL);
        rd(IDX_DIV, RST_DIV);
        rd(IDX_BIAS, RST_BIAS);
        rd(IDX_STAT, 8'h07);
        rd(8'h20, 8'h00);
        $display("test reset done");
        wr(IDX_DIV, 8'h03);
        tl = 8'h70 | (8'($random(seed)) & 8'h07);
        wr(IDX_VOL_L, tl);
        wr(IDX_VOL_R, 8'h7c);
        wr(IDX_PWR, 8'h07);
        wt(0, 1'b1);
        chk(gain_l, MUTE_CODE);
        ramp(tl, 8'h7c);
        chk({7'h0, nt >= int'(8'h80 - tl) && nt <= int'(8'h82 - tl)}, 8'h01);
        chk({6'h0, r_on, l_on}, 8'h03);
        rd(IDX_STAT, 8'h03);
        wr(IDX_VOL_M, 8'h05);
        rd(IDX_STAT, 8'h00);
        ramp(8'h05, 8'h05);
        rd(IDX_STAT, 8'h03);
        $display("test power-up and master done");
        wr(IDX_CTRL, 8'h02);
        wr(IDX_VOL_L, 8'h09);
        ramp(8'h09, 8'h05);
        chk({7'h0, nt >= 7 && nt <= 9}, 8'h01);
        wr(IDX_CTRL, 8'h04);
        wt(1, 1'b1);
        chk(gain_l, MUTE_CODE);
        chk({6'h0, fx_on, de_on}, 8'h01);
        ramp(8'h09, 8'h05);
        wr(IDX_CTRL, 8'h0c);
        wt(2, 1'b1);
        chk(gain_r, MUTE_CODE);
        chk({6'h0, fx_on, de_on}, 8'h03);
        ramp(8'h09, 8'h05);
        $display("test rate and filter done");
        soft_on = 1'b0;
        wr(IDX_CTRL, 8'h0d);
        wr(IDX_VOL_L, 8'h40);
        repeat (2) @(posedge mclk);
        chk(gain_l, 8'h40);
        wr(IDX_CTRL, 8'h0c);
        soft_on = 1'b1;
        wr(IDX_BIAS, 8'hc0);
        wr(IDX_CM, 8'h03);
        wr(IDX_INCFG, 8'h00);
        wr(IDX_INLVL, 8'hf3);
        wr(IDX_PWR, 8'h03);
        repeat (200) @(posedge mclk);
        chk({4'h0, cm, bias}, 8'h0f);
        chk({lvl_r, lvl_l}, 8'h83);
        chk({6'h0, r_on, l_on}, 8'h01);
        rd(IDX_BIAS, 8'hc0);
        $display("test settings done");
        wr(IDX_PWR, 8'h00);
        wt(0, 1'b0);
        chk(gain_l, MUTE_CODE);
        rd(IDX_STAT, 8'h04);
        $display("test power-down done");
        close_out();
    end
endmodule
